// ==== core/spims_port.sv ====
// Byte-wide serial peripheral port, master or slave
// Summary of operation
// [R1] Master never drives the select line itself
// [R2] Master data write shifts exactly eight bits
// [R3] Master clock stops, done flag sets
// [R4] Done flag with enable raises interrupt
// [R5] Received byte kept in receive buffer
// [R6] Deselected slave keeps data output released
// [R7] Slave ignores clock edges while deselected
// [R8] Slave sets done flag per full byte
// [R9] Slave may load next byte before reading
// [R10] Software writes only after shift completes
// [R11] Software reads byte before next completes
// [R12] Far master keeps clock phases above two
// [R13] Enabled port forces listed pins to input
// [R14] Other pin directions follow software choice
// [R15] Full duplex, master supplies every clock
// [R16] Far master frames packets with select
// [R17] Bit order selectable, low or high first
// [R18] Seven master rates including half CPU clock
// [R19] Write during transfer sets collision flag
// [R20] Done event can wake idle processor
// [R21] Slave bit counter cleared while deselected
module spims_port (
   input  wire logic       i_mclk,
   input  wire logic       i_srst,
   input  wire logic       i_serial_port_enable,
   input  wire logic       i_master_select_bit,
   input  wire logic       i_lsb_first,
   input  wire logic [1:0] i_rate_sel,
   input  wire logic       i_double_speed,
   input  wire logic       i_serial_irq_enable,
   input  wire logic       i_data_wr,
   input  wire logic [7:0] i_data_wdata,
   input  wire logic       i_data_rd,
   input  wire logic       i_dir_mosi,
   input  wire logic       i_dir_miso,
   input  wire logic       i_dir_sck,
   input  wire logic       i_sck,
   input  wire logic       i_ss_n,
   input  wire logic       i_mosi,
   input  wire logic       i_miso,
   output logic [7:0]      o_rx_data,
   output logic [7:0]      o_tx_data,
   output logic            o_transfer_done_flag,
   output logic            o_wcol_flag,
   output logic            o_irq,
   output logic            o_wake,
   output logic            o_busy,
   output logic            o_sck,
   output logic            o_sck_oe,
   output logic            o_mosi,
   output logic            o_mosi_oe,
   output logic            o_miso,
   output logic            o_miso_oe
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   spims_pkg::spims_mstate_type state;
   logic [5:0] div_cnt;
   logic [2:0] bit_cnt;
   logic [7:0] sh;
   logic [2:0] lk_cnt;
   logic [7:0] lk_rx;
   logic [7:0] lk_rx_word;
   logic       lk_done_tgl;
   logic [3:0] h_smp;
   logic [5:0] h_ph;

   spims_sync_if ss_if ();
   spims_sync_if tg_if ();

   // ---------------------------------------------------------------
   // Crossings into the CPU clock
   // ---------------------------------------------------------------
   // [R16] Select framing seen here
   assign ss_if.raw = i_ss_n;
   assign tg_if.raw = lk_done_tgl;

   spims_sync3 #(.RST_VAL(spims_pkg::SS_IDLE)) u_ss_sync (
      .i_clk  (i_mclk),
      .i_srst (i_srst),
      .sif    (ss_if)
   );

   spims_sync3 #(.RST_VAL(1'b0)) u_done_sync (
      .i_clk  (i_mclk),
      .i_srst (i_srst),
      .sif    (tg_if)
   );

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire       en_m     = i_serial_port_enable && i_master_select_bit;
   wire       en_s     = i_serial_port_enable && !i_master_select_bit;
   wire       ss_high  = ss_if.level;
   wire       m_idle   = (state == spims_pkg::M_IDLE);
   wire       m_high   = (state == spims_pkg::M_HIGH);
   wire       m_low    = (state == spims_pkg::M_LOW);
   wire       tick     = (div_cnt == 6'h00);
   wire [2:0] rcode    = {i_double_speed, i_rate_sel};
   wire       busy     = (en_m && !m_idle) || (en_s && !ss_high);
   wire       wr_ok    = i_data_wr && !busy;
   wire       wr_coll  = i_data_wr && busy;
   wire       start_m  = wr_ok && en_m;
   wire       done_m   = en_m && m_low && tick && (bit_cnt == spims_pkg::LAST_BIT);
   wire       done_s   = en_s && tg_if.changed;
   wire       set_done = done_m || done_s;
   wire       out_bit  = i_lsb_first ? sh[0] : sh[7];
   wire       wr_bit   = i_lsb_first ? i_data_wdata[0] : i_data_wdata[7];

   // [R18] Seven distinct rates, fastest is half the CPU clock
   wire [5:0] half_m1 = (rcode == 3'h0) ? spims_pkg::HALF_N0 :
                        (rcode == 3'h1) ? spims_pkg::HALF_N1 :
                        (rcode == 3'h2) ? spims_pkg::HALF_N2 :
                        (rcode == 3'h3) ? spims_pkg::HALF_N3 :
                        (rcode == 3'h4) ? spims_pkg::HALF_D0 :
                        (rcode == 3'h5) ? spims_pkg::HALF_D1 :
                        (rcode == 3'h6) ? spims_pkg::HALF_D2 :
                                          spims_pkg::HALF_D3;

   // [R15] [R17] Sample the return line into the far end of the shifter
   wire [7:0] next_sh = i_lsb_first ? {i_miso, sh[7:1]} : {sh[6:0], i_miso};

   // ---------------------------------------------------------------
   // Data register, written only when no byte is on the wire
   // ---------------------------------------------------------------
   // [R9] [R10] [R19] Deselected slave accepts writes; busy writes are dropped
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_tx_data <= spims_pkg::DATA_RST;
      end else if (wr_ok) begin
         o_tx_data <= i_data_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Master sequencer: clock idles low, drive on rise, sample on fall
   // ---------------------------------------------------------------
   // [R2] [R3] Eight clock pulses per write, then halt
   always_ff @(posedge i_mclk) begin
      if (i_srst || !en_m) begin
         state   <= spims_pkg::M_IDLE;
         div_cnt <= 6'h00;
         bit_cnt <= 3'h0;
         o_sck   <= 1'b0;
      end else begin
         unique case (state)
            spims_pkg::M_IDLE: begin
               if (start_m) begin
                  state   <= spims_pkg::M_HIGH;
                  div_cnt <= half_m1;
                  bit_cnt <= 3'h0;
                  o_sck   <= 1'b1;
               end
            end
            spims_pkg::M_HIGH: begin
               div_cnt <= tick ? half_m1 : div_cnt - 6'h01;
               if (tick) begin
                  state <= spims_pkg::M_LOW;
                  o_sck <= 1'b0;
               end
            end
            spims_pkg::M_LOW: begin
               div_cnt <= tick ? half_m1 : div_cnt - 6'h01;
               if (tick && bit_cnt == spims_pkg::LAST_BIT) begin
                  state <= spims_pkg::M_IDLE;
               end else if (tick) begin
                  state   <= spims_pkg::M_HIGH;
                  bit_cnt <= bit_cnt + 3'h1;
                  o_sck   <= 1'b1;
               end
            end
         endcase
      end
   end

   // Shifter and outgoing master data bit
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         sh     <= spims_pkg::DATA_RST;
         o_mosi <= 1'b0;
      end else if (start_m) begin
         sh     <= i_data_wdata;
         o_mosi <= wr_bit;
      end else if (en_m && m_high && tick) begin
         sh <= next_sh;
      end else if (en_m && m_low && tick) begin
         o_mosi <= out_bit;
      end
   end

   // ---------------------------------------------------------------
   // Slave shifter on the far master's clock
   // ---------------------------------------------------------------
   // Bit index follows the order bit; data register is quiet while selected
   wire [2:0] lk_idx    = i_lsb_first ? lk_cnt : spims_pkg::LAST_BIT - lk_cnt;
   wire [7:0] next_lk_rx = i_lsb_first ? {i_mosi, lk_rx[7:1]} : {lk_rx[6:0], i_mosi};
   wire       lk_last   = (lk_cnt == spims_pkg::LAST_BIT);

   // [R7] [R21] Select high holds the bit counter at zero
   always_ff @(negedge i_sck or posedge i_ss_n) begin
      if (i_ss_n) begin
         lk_cnt <= 3'h0;
      end else begin
         lk_cnt <= lk_cnt + 3'h1;
      end
   end
   // [R6] [R15] Slave output moves on the rising clock edge
   always_ff @(posedge i_sck or posedge i_ss_n) begin
      if (i_ss_n) begin
         o_miso <= 1'b0;
      end else begin
         o_miso <= o_tx_data[lk_idx];
      end
   end
   // Incoming bits; the assembled word stands for a whole byte time
   always_ff @(negedge i_sck) begin
      lk_rx <= next_lk_rx;
      if (lk_last && !i_ss_n) begin
         lk_rx_word <= next_lk_rx;
      end
   end
   // [R8] Byte end crosses as a toggle, immune to clock ratio
   always_ff @(negedge i_sck or posedge i_srst) begin
      if (i_srst) begin
         lk_done_tgl <= 1'b0;
      end else if (lk_last && !i_ss_n) begin
         lk_done_tgl <= !lk_done_tgl;
      end
   end

   // ---------------------------------------------------------------
   // Receive buffer and flags
   // ---------------------------------------------------------------
   // [R5] [R11] Newest byte overwrites an unread one
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_rx_data <= spims_pkg::DATA_RST;
      end else if (done_m) begin
         o_rx_data <= sh;
      end else if (done_s) begin
         o_rx_data <= lk_rx_word;
      end
   end
   // [R3] [R8] [R19] Set wins over a read in the same cycle
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_transfer_done_flag <= 1'b0;
         o_wcol_flag          <= 1'b0;
      end else begin
         o_transfer_done_flag <= set_done || (o_transfer_done_flag && !i_data_rd);
         o_wcol_flag          <= wr_coll || (o_wcol_flag && !i_data_rd);
      end
   end
   // [R4] [R20] Request and wake pulse, both gated by the enable
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_irq  <= 1'b0;
         o_wake <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         o_irq  <= o_transfer_done_flag && i_serial_irq_enable;
         o_wake <= set_done && i_serial_irq_enable;
         o_busy <= busy;
      end
   end

   // ---------------------------------------------------------------
   // Pin direction overrides
   // ---------------------------------------------------------------
   // [R1] [R13] [R14] No select output; forced inputs never enabled
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_sck_oe  <= 1'b0;
         o_mosi_oe <= 1'b0;
         o_miso_oe <= 1'b0;
      end else begin
         o_sck_oe  <= en_m && i_dir_sck;
         o_mosi_oe <= en_m && i_dir_mosi;
         o_miso_oe <= en_s && i_dir_miso && !ss_high;
      end
   end

   // ---------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------
   // Samples per transfer and cycles spent in the high phase
   always_ff @(posedge i_mclk) begin
      if (i_srst || start_m) begin
         h_smp <= 4'h0;
      end else if (en_m && m_high && tick) begin
         h_smp <= h_smp + 4'h1;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_srst || !m_high) begin
         h_ph <= 6'h00;
      end else begin
         h_ph <= h_ph + 6'h01;
      end
   end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_srst);

   property p_start;
      start_m |=> (state == spims_pkg::M_HIGH) && o_sck;
   endproperty
   a_start: assert property (p_start) else $error("master write did not start clock"); // [R2]
   property p_eight;
      done_m |-> (h_smp == spims_pkg::BYTE_BITS);
   endproperty
   a_eight: assert property (p_eight) else $error("master byte not eight bits"); // [R2]
   property p_halt;
      done_m |=> (state == spims_pkg::M_IDLE) && !o_sck && o_transfer_done_flag;
   endproperty
   a_halt: assert property (p_halt) else $error("clock not halted with flag"); // [R3]
   property p_irq;
      ($rose(o_transfer_done_flag) && i_serial_irq_enable) |=> o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised"); // [R4]
   property p_rxbuf;
      done_m |=> (o_rx_data == $past(sh));
   endproperty
   a_rxbuf: assert property (p_rxbuf) else $error("received byte not buffered"); // [R5]
   property p_slv_hiz;
      (en_s && ss_high) |=> !o_miso_oe;
   endproperty
   a_slv_hiz: assert property (p_slv_hiz) else $error("slave output on while idle"); // [R6]
   property p_slv_done;
      done_s |=> o_transfer_done_flag ##1 o_irq == $past(i_serial_irq_enable);
   endproperty
   a_slv_done: assert property (p_slv_done) else $error("slave byte flag missing"); // [R8]
   property p_dir;
      (o_mosi_oe || o_sck_oe) |-> $past(en_m) && !o_miso_oe;
   endproperty
   a_dir: assert property (p_dir) else $error("forced input pin driven"); // [R13]
   property p_order;
      start_m |=> o_mosi == $past(i_lsb_first ? i_data_wdata[0] : i_data_wdata[7]);
   endproperty
   a_order: assert property (p_order) else $error("wrong first bit"); // [R17]
   property p_half;
      (en_m && m_high && tick) |-> (h_ph == half_m1);
   endproperty
   a_half: assert property (p_half) else $error("clock phase length wrong"); // [R18]
   property p_wcol;
      wr_coll |=> o_wcol_flag && $stable(o_tx_data);
   endproperty
   a_wcol: assert property (p_wcol) else $error("collision not flagged"); // [R19]
   property p_wake;
      (set_done && i_serial_irq_enable) |=> o_wake;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake pulse"); // [R20]

   // Main scenarios
   c_master_done: cover property (done_m);
   c_slave_done: cover property (done_s);
   c_collision: cover property (wr_coll);
   c_lsb_done: cover property (done_m && i_lsb_first);

endmodule

// ==== core/spims_pkg.sv ====
// Shared constants and types of the serial peripheral port
package spims_pkg;

   // ---------------------------------------------------------------
   // Byte framing
   // ---------------------------------------------------------------
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [7:0] DATA_RST  = 8'h00;
   localparam logic       SS_IDLE   = 1'b1;

   // ---------------------------------------------------------------
   // Master clock half period, minus one, per rate code
   // ---------------------------------------------------------------
   localparam logic [5:0] HALF_N0 = 6'h01;   // Divide by 4
   localparam logic [5:0] HALF_N1 = 6'h07;   // Divide by 16
   localparam logic [5:0] HALF_N2 = 6'h1F;   // Divide by 64
   localparam logic [5:0] HALF_N3 = 6'h3F;   // Divide by 128
   localparam logic [5:0] HALF_D0 = 6'h00;   // Divide by 2, double speed
   localparam logic [5:0] HALF_D1 = 6'h03;   // Divide by 8, double speed
   localparam logic [5:0] HALF_D2 = 6'h0F;   // Divide by 32, double speed
   localparam logic [5:0] HALF_D3 = 6'h1F;   // Divide by 64, double speed

   // Least slave clock phase in CPU cycles, kept by the far master
   localparam int SLV_MIN_PHASE_CYC = 2;

   // ---------------------------------------------------------------
   // Master sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      M_IDLE = 3'b001,
      M_HIGH = 3'b010,
      M_LOW  = 3'b100
   } spims_mstate_type;

endpackage

// ==== core/spims_sync_if.sv ====
// Carrier between the port and its three-stage synchroniser
interface spims_sync_if;
   logic raw;
   logic level;
   logic changed;
   modport sync_side (input raw, output level, output changed);
   modport user_side (output raw, input level, input changed);
endinterface

// ==== core/spims_sync3.sv ====
// Three-stage synchroniser with agreement filter and change pulse
module spims_sync3 #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   spims_sync_if.sync_side  sif
);

   // ---------------------------------------------------------------
   // Stages
   // ---------------------------------------------------------------
   logic q1;
   logic q2;
   logic q3;
   logic level;
   logic changed;
   wire  agree = (q2 == q3);

   // First stage feeds only the second, so metastability stays contained
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         q1 <= RST_VAL;
         q2 <= RST_VAL;
         q3 <= RST_VAL;
      end else begin
         q1 <= sif.raw;
         q2 <= q1;
         q3 <= q2;
      end
   end

   // Level moves only when two late stages agree
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         level   <= RST_VAL;
         changed <= 1'b0;
      end else begin
         level   <= agree ? q3 : level;
         changed <= agree && (q3 != level);
      end
   end

   assign sif.level   = level;
   assign sif.changed = changed;

endmodule

// ==== test/spims_peer.sv ====
// Far-side peer: slave when the port is master, master when the port is slave
module spims_peer (
   input  wire logic i_lsb_first,
   input  wire logic i_sck,
   input  wire logic i_mosi,
   input  wire logic i_miso,
   output logic      o_miso,
   output logic      o_sck,
   output logic      o_ss_n,
   output logic      o_mosi
);
   timeunit 1ns;
   timeprecision 10ps;

   logic [7:0] s_tx = 8'h00;
   logic [7:0] s_rx = 8'h00;
   int         s_cnt = 0;

   // Lines idle with select released and clock still
   initial begin
      o_miso = 1'b0;
      o_sck = 1'b0;
      o_ss_n = 1'b1;
      o_mosi = 1'b0;
   end

   // ---------------------------------------------------------------
   // Slave role
   // ---------------------------------------------------------------
   // Full duplex reply
   always @(posedge i_sck) begin
      o_miso <= i_lsb_first ? s_tx[s_cnt] : s_tx[7 - s_cnt];
   end

   // Sample on fall
   // After the byte the line flips, so a stale bit is never mistaken for data
   always @(negedge i_sck) begin
      s_rx <= i_lsb_first ? {i_mosi, s_rx[7:1]} : {s_rx[6:0], i_mosi};
      if (s_cnt == 7) begin
         s_cnt <= 0;
         o_miso <= ~o_miso;
      end else begin
         s_cnt <= s_cnt + 1;
      end
   end

   // ---------------------------------------------------------------
   // Master role
   // ---------------------------------------------------------------
   // Framed clocks
   // 125 ns period gives phases far above two CPU cycles; clock runs in frames only
   task automatic frame(input logic [7:0] d, input int nbits, input logic sel,
                        output logic [7:0] r);
      r = 8'h00;
      #3.7 o_ss_n = ~sel;
      #100;
      for (int i = 0; i < nbits; i++) begin
         o_mosi = i_lsb_first ? d[i] : d[7 - i];
         #31.25 o_sck = 1'b1;
         #62.5 o_sck = 1'b0;
         r = i_lsb_first ? {i_miso, r[7:1]} : {r[6:0], i_miso};
         #31.25;
      end
      #100 o_ss_n = 1'b1;
      o_mosi = ~o_mosi;
   endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench of the serial port in master and slave roles
module testbench;
   timeunit 1ns;
   timeprecision 10ps;

   logic       i_mclk = 1'b0;
   logic       i_srst;
   logic       en = 1'b0, mst = 1'b0, lsb = 1'b0, dbl = 1'b0, irqen = 1'b0;
   logic [1:0] rate = 2'h0;
   logic       wr = 1'b0, rd = 1'b0, dmo = 1'b0, dmi = 1'b0, dsk = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [7:0] rx, tx, r;
   logic       done, wcol, irq, wake, busy, msck, msck_oe, mmosi, mmosi_oe;
   logic       smiso, smiso_oe, psck, pss_n, pmosi, pmiso;
   int         n_fail = 0, tests_run = 0, n, nsck = 0, nwake = 0;
   int         hv[8] = '{2, 8, 32, 64, 1, 4, 16, 32};

   always #5 i_mclk = ~i_mclk;
   always @(posedge msck) nsck++;
   always @(posedge i_mclk) if (wake === 1'b1) nwake++;

   spims_port dut (
      .i_mclk(i_mclk), .i_srst(i_srst), .i_serial_port_enable(en),
      .i_master_select_bit(mst), .i_lsb_first(lsb), .i_rate_sel(rate),
      .i_double_speed(dbl), .i_serial_irq_enable(irqen), .i_data_wr(wr),
      .i_data_wdata(wd), .i_data_rd(rd), .i_dir_mosi(dmo), .i_dir_miso(dmi),
      .i_dir_sck(dsk), .i_sck(psck), .i_ss_n(pss_n), .i_mosi(pmosi), .i_miso(pmiso),
      .o_rx_data(rx), .o_tx_data(tx), .o_transfer_done_flag(done), .o_wcol_flag(wcol),
      .o_irq(irq), .o_wake(wake), .o_busy(busy), .o_sck(msck), .o_sck_oe(msck_oe),
      .o_mosi(mmosi), .o_mosi_oe(mmosi_oe), .o_miso(smiso), .o_miso_oe(smiso_oe));

   spims_peer peer (
      .i_lsb_first(lsb), .i_sck(msck), .i_mosi(mmosi), .i_miso(smiso),
      .o_miso(pmiso), .o_sck(psck), .o_ss_n(pss_n), .o_mosi(pmosi));

   task automatic finish_test();
      if (n_fail == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (exp !== got) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Data register write; returns in the edge that takes it
   task automatic wr_byte(input logic [7:0] d);
      @(posedge i_mclk);
      wr <= 1'b1;
      wd <= d;
      @(posedge i_mclk);
      wr <= 1'b0;
   endtask

   task automatic rd_pulse();
      @(posedge i_mclk);
      rd <= 1'b1;
      @(posedge i_mclk);
      rd <= 1'b0;
   endtask

   // Cycles from the taking edge to the flag, bounded
   task automatic wait_done(output int k);
      k = 1;
      while (done !== 1'b1) begin
         @(posedge i_mclk);
         k++;
         #1;
         if (k > 3000) begin
            n_fail++;
            finish_test();
         end
      end
   endtask

   initial begin
      #900us;
      n_fail++;
      finish_test();
   end

   initial begin
      // A real rising edge at time zero clears the link-side toggle as well
      i_srst <= 1'b1;
      repeat (10) @(posedge i_mclk);
      i_srst <= 1'b0;
      @(posedge i_mclk);
      #1 chk("rx_rst", 16'h0000, {8'h00, rx});
      chk("done_rst", 16'h0000, {15'h0, done});
      // Master: ask for every pin as output, the data input must still stay input
      @(posedge i_mclk);
      {en, mst, irqen, dmo, dmi, dsk} <= 6'h3F;
      repeat (3) @(posedge i_mclk);
      #1 chk("mosi_oe", 16'h0001, {15'h0, mmosi_oe});
      chk("sck_oe", 16'h0001, {15'h0, msck_oe});
      chk("miso_oe_m", 16'h0000, {15'h0, smiso_oe});
      for (int c = 0; c < 8; c++) begin
         @(posedge i_mclk);
         {dbl, rate} <= c[2:0];
         lsb <= c[0];
         peer.s_tx = 8'hA5 ^ 8'(c);
         nsck = 0;
         nwake = 0;
         wr_byte(8'h3C + 8'(c));
         wait_done(n);
         chk("cycles", 16'(16 * hv[c] + 1), 16'(n));
         chk("sck_rises", 16'h0008, 16'(nsck));
         chk("rx", {8'h00, 8'hA5 ^ 8'(c)}, {8'h00, rx});
         chk("peer_rx", {8'h00, 8'h3C + 8'(c)}, {8'h00, peer.s_rx});
         @(posedge i_mclk);
         #1 chk("irq", 16'h0001, {15'h0, irq});
         chk("wake", 16'h0001, 16'(nwake));
         rd_pulse();
         #1 chk("done_clr", 16'h0000, {15'h0, done});
      end
      // Write during transfer: refused and flagged; no interrupt when disabled
      @(posedge i_mclk);
      irqen <= 1'b0;
      wr_byte(8'h11);
      repeat (3) @(posedge i_mclk);
      wr_byte(8'h22);
      @(posedge i_mclk);
      #1 chk("wcol", 16'h0001, {15'h0, wcol});
      chk("busy_on", 16'h0001, {15'h0, busy});
      chk("tx_kept", 16'h0011, {8'h00, tx});
      wait_done(n);
      chk("peer_rx_c", 16'h0011, {8'h00, peer.s_rx});
      repeat (2) @(posedge i_mclk);
      #1 chk("irq_off", 16'h0000, {15'h0, irq});
      chk("busy_off", 16'h0000, {15'h0, busy});
      rd_pulse();
      #1 chk("wcol_clr", 16'h0000, {15'h0, wcol});
      // Slave: clock and data input forced to input
      @(posedge i_mclk);
      {mst, lsb, irqen} <= 3'b001;
      repeat (5) @(posedge i_mclk);
      #1 chk("sck_oe_s", 16'h0000, {15'h0, msck_oe});
      chk("mosi_oe_s", 16'h0000, {15'h0, mmosi_oe});
      chk("miso_oe_idle", 16'h0000, {15'h0, smiso_oe});
      wr_byte(8'hC3);
      peer.frame(8'hFF, 8, 1'b0, r);
      repeat (10) @(posedge i_mclk);
      #1 chk("desel_done", 16'h0000, {15'h0, done});
      peer.frame(8'h5A, 3, 1'b1, r);
      repeat (10) @(posedge i_mclk);
      #1 chk("part_done", 16'h0000, {15'h0, done});
      fork
         peer.frame(8'h96, 8, 1'b1, r);
         begin
            repeat (9) @(posedge i_mclk);
            #1 chk("miso_oe_sel", 16'h0001, {15'h0, smiso_oe});
         end
      join
      wait_done(n);
      repeat (2) @(posedge i_mclk);
      #1 chk("s_rx", 16'h0096, {8'h00, rx});
      chk("s_tx", 16'h00C3, {8'h00, r});
      chk("s_irq", 16'h0001, {15'h0, irq});
      repeat (6) @(posedge i_mclk);
      #1 chk("miso_oe_off", 16'h0000, {15'h0, smiso_oe});
      // Next byte loaded before the received one is read, low bit first
      @(posedge i_mclk);
      lsb <= 1'b1;
      wr_byte(8'h69);
      rd_pulse();
      peer.frame(8'h0F, 8, 1'b1, r);
      wait_done(n);
      repeat (2) @(posedge i_mclk);
      #1 chk("s_tx2", 16'h0069, {8'h00, r});
      chk("s_rx2", 16'h000F, {8'h00, rx});
      chk("s_wcol", 16'h0000, {15'h0, wcol});
      finish_test();
   end
endmodule
